// *** pulse_source.sv ***
`timescale 1ns/1ps
module pulse_source (
    // Clock.
    input wire logic clk,
    // Driven input pin.
    output logic pin
);
    initial begin
        pin = 1'b0;
    end
    // A level is held for a whole number of cycles, changed just after the edge.
    task automatic hold(input logic v, input int n);
        @(posedge clk);
        pin <= v;
        repeat (n - 1) @(posedge clk);
    endtask : hold
    // A short high time is a glitch that the input filters must reject.
    task automatic pulse(input int hi, input int lo);
        hold(1'b1, hi);
        hold(1'b0, lo);
    endtask : pulse
endmodule : pulse_source

// *** test_timer_event_counter.sv ***
`timescale 1ns/1ps
`include "timer_consts.svh"
module test_timer_event_counter;
    localparam int LIMIT = 80000;
    logic clk = 1'b0;
    logic srst = 1'b1;
    timer_pkg::reg_req_t req = '0;
    logic [15:0] rdata;
    logic first_timer_input;
    logic second_timer_input;
    logic timer_output_pin;
    logic timer_output_enable;
    logic match_irq;
    logic capture_irq;
    logic overflow_flag;
    int failures = 0;
    int n_compared = 0;
    int cyc = 0;
    int n_match = 0;
    int n_cap = 0;
    int t_match = 0;
    int t_prev = 0;
    int seed;
    always #20 clk = ~clk;
    timer_event_counter uut (
        .clk(clk),
        .srst(srst),
        .req(req),
        .rdata(rdata),
        .first_timer_input(first_timer_input),
        .second_timer_input(second_timer_input),
        .timer_output_pin(timer_output_pin),
        .timer_output_enable(timer_output_enable),
        .match_irq(match_irq),
        .capture_irq(capture_irq),
        .overflow_flag(overflow_flag)
    );
    pulse_source src1 (.clk(clk), .pin(first_timer_input));
    pulse_source src2 (.clk(clk), .pin(second_timer_input));
    // Request pulses are counted and match pulses stamped, so intervals need no polling.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (match_irq === 1'b1) begin
            n_match <= n_match + 1;
            t_prev <= t_match;
            t_match <= cyc;
        end
        if (capture_irq === 1'b1) begin
            n_cap <= n_cap + 1;
        end
    end
    always @(posedge clk) begin
        if (cyc == LIMIT) begin
            failures++;
            tally_and_finish();
        end
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge clk);
        req <= '{we: 1'b1, re: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        req <= '0;
    endtask : wr
    task automatic rd(input logic [2:0] a, output logic [15:0] v);
        @(posedge clk);
        req <= '{we: 1'b0, re: 1'b1, addr: a, wdata: 16'h0000};
        @(posedge clk);
        req <= '0;
        #1;
        v = rdata;
    endtask : rd
    task automatic setup(input logic [1:0] ccc, input logic [15:0] pri,
                         input logic [7:0] pcfg, input logic [2:0] mode);
        wr(`OFS_MODE_CONTROL, 16'h0000);
        wr(`OFS_CAPTURE_CONTROL, {14'h0000, ccc});
        wr(`OFS_PRIMARY, pri);
        wr(`OFS_PRESCALER_CONFIG, {8'h00, pcfg});
        wr(`OFS_MODE_CONTROL, {13'h0000, mode});
    endtask : setup
    task automatic wait_ev(input bit cap, input int tgt, input int lim);
        int i;
        for (i = 0; i < lim; i++) begin
            @(posedge clk);
            #1;
            if ((cap ? n_cap : n_match) >= tgt) begin
                break;
            end
        end
        if (i == lim) begin
            failures++;
            $display("Error at %0t ns: awaited request never came", $time);
        end
    endtask : wait_ev
    task automatic tally_and_finish();
        $display("Compared %0d, mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        logic [15:0] v;
        logic [15:0] a;
        int n;
        int k;
        int e;
        int m;
        seed = $urandom(32'h2E3D);
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            rd(i[2:0], v);
            check(v, 16'h0000);
        end
        v = 16'($urandom());
        wr(`OFS_PRIMARY, v);
        wr(`OFS_UP_COUNTER, 16'h1234);
        wr(3'h7, 16'hFFFF);
        wr(`OFS_PRESCALER_CONFIG, 16'h00FF);
        rd(`OFS_PRIMARY, a);
        check(a, v);
        rd(`OFS_UP_COUNTER, a);
        check(a, 16'h0000);
        rd(3'h7, a);
        check(a, 16'h0000);
        rd(`OFS_PRESCALER_CONFIG, a);
        check(a, 16'h00F3);
        $display("Test registers done");
        for (int s = 0; s < 3; s++) begin
            n = $urandom_range(7, 1);
            setup(2'h0, 16'(n), {6'h00, s[1:0]}, {1'b0, `MODE_CLEAR_ON_MATCH});
            wait_ev(1'b0, n_match + 2, 2000);
            e = (n + 1) * ((s == 0) ? 1 : (s == 1) ? 4 : 64);
            check(16'(t_match - t_prev), 16'(e));
            check({15'h0000, overflow_flag}, 16'h0000);
        end
        $display("Test interval done");
        for (int c = 0; c < 4; c++) begin
            k = $urandom_range(6, 1);
            setup(2'h0, 16'h0003, {2'h0, c[1:0], 4'h3},
                  {1'b1, `MODE_CLEAR_ON_MATCH});
            n = n_match;
            repeat (k) src1.pulse(24, 24);
            src1.pulse(5, 30);
            e = (c == 2) ? 0 : (c == 3) ? 2 * k : k;
            rd(`OFS_UP_COUNTER, v);
            check(v, 16'(e % 4));
            check(16'(n_match - n), 16'(e / 4));
            check({15'h0000, timer_output_enable}, 16'h0000);
            check({15'h0000, timer_output_pin}, 16'h0000);
        end
        $display("Test event counter done");
        setup(2'h1, 16'h0000, 8'hF0, {1'b0, `MODE_FREE_RUN});
        for (int p = 0; p < 3; p++) begin
            // The last pass captures the inverse edge of the first input into primary.
            if (p == 2) begin
                setup(2'h2, 16'h0000, 8'h10, {1'b0, `MODE_FREE_RUN});
            end
            n = (p == 1) ? n_match : n_cap;
            m = n_match;
            k = $urandom_range(60, 30);
            fork
                if (p == 1) src2.pulse(k, 40); else src1.pulse(k, 40);
                begin
                    wait_ev(p != 1, n + 1, 60);
                    rd((p == 1) ? `OFS_PRIMARY : `OFS_SECONDARY, a);
                    wait_ev(p == 0, (p == 2) ? m + 1 : n + 2, 100);
                    rd((p == 0) ? `OFS_SECONDARY : `OFS_PRIMARY, v);
                end
            join
            check(v - a, 16'(k));
        end
        n = n_cap;
        src1.pulse(1, 10);
        check(16'(n_cap - n), 16'h0000);
        $display("Test free-running capture done");
        setup(2'h0, 16'h0000, 8'h10, {1'b0, `MODE_RESTART});
        n = n_cap;
        fork
            repeat (4) src1.pulse(20, 30);
            begin
                wait_ev(1'b1, n + 2, 120);
                rd(`OFS_SECONDARY, a);
                wait_ev(1'b1, n + 3, 120);
                rd(`OFS_SECONDARY, v);
            end
        join
        check(a, 16'h0031);
        check(v, a);
        $display("Test restart capture done");
        setup(2'h0, 16'hFFFF, 8'h00, {1'b0, `MODE_CLEAR_ON_MATCH});
        wait_ev(1'b0, n_match + 1, 66000);
        repeat (20) @(posedge clk);
        check({15'h0000, overflow_flag}, 16'h0001);
        wr(`OFS_STATUS, 16'h0001);
        rd(`OFS_STATUS, v);
        check(v, 16'h0000);
        $display("Test overflow done");
        tally_and_finish();
    end
endmodule : test_timer_event_counter

// *** timer_consts.svh ***
`ifndef TIMER_CONSTS_SVH
`define TIMER_CONSTS_SVH

// Register offsets on the plain register port.
`define OFS_UP_COUNTER 3'h0
`define OFS_PRIMARY 3'h1
`define OFS_SECONDARY 3'h2
`define OFS_MODE_CONTROL 3'h3
`define OFS_PRESCALER_CONFIG 3'h4
`define OFS_CAPTURE_CONTROL 3'h5
`define OFS_STATUS 3'h6

// Reset values.
`define RST_WORD 16'h0000
`define RST_BYTE 8'h00
`define RST_MODE 2'h0

// Field positions.
`define MODE_LSB 0
`define MODE_OUT_EN_BIT 2
`define CCC_PRI_CAPTURE_BIT 0
`define CCC_INV_EDGE_BIT 1
`define PCFG_CLOCK_SEL_LSB 0
`define PCFG_FIRST_EDGE_LSB 4
`define PCFG_SECOND_EDGE_LSB 6
`define PCFG_WRITE_MASK 8'hF3
`define STATUS_OVF_BIT 0

// Operating mode codes.
`define MODE_STOP 2'h0
`define MODE_FREE_RUN 2'h1
`define MODE_CLEAR_ON_MATCH 2'h2
`define MODE_RESTART 2'h3

// Count clock select codes.
`define CLK_SEL_MAIN 2'h0
`define CLK_SEL_DIV4 2'h1
`define CLK_SEL_DIV64 2'h2
`define CLK_SEL_PIN_EDGE 2'h3

// Edge select codes; code 2 is prohibited and detects nothing.
`define EDGE_FALL 2'h0
`define EDGE_RISE 2'h1
`define EDGE_BOTH 2'h3

// Prescaler taps: divide by four, by sixty-four, and by eight for event sampling.
`define PRESC_W 6
`define DIV4_MASK 6'h03
`define DIV8_MASK 6'h07
`define DIV64_MASK 6'h3F
`define COUNT_MAX 16'hFFFF

`endif

// *** timer_event_counter.sv ***
`timescale 1ns/1ps
`include "timer_consts.svh"
// Overview of operation
// (RQ1) Interval mode: counter equal to primary clears to zero and raises match request.
// (RQ2) Count clock chosen by two-bit select in prescaler config bits 0 and 1.
// (RQ3) Interval equals compare value plus one count clock periods.
// (RQ4) Compare rewritten below count: counter runs to overflow, wraps; software restarts.
// (RQ5) Clear-on-match modes set overflow only when primary holds FFFFH.
// (RQ6) Event mode: counter increments once per valid first-input edge.
// (RQ7) Event mode: count equal to primary clears counter and raises match request.
// (RQ8) Software programs a nonzero primary before starting event counting.
// (RQ9) First-input edge selected by prescaler config bits 4 and 5.
// (RQ10) Event input sampled at clock over eight, two equal samples confirm.
// (RQ11) Pin used as event input never drives the timer output.
// (RQ12) Software reads the event count from the counter register.
// (RQ13) Capture inputs sampled at count clock, two equal samples confirm.
// (RQ14) Hardware never clears overflow; software clears it after each capture.
// (RQ15) Free-running: first-input edge copies counter to secondary, raises capture request.
// (RQ16) Dual width: second-input edge copies counter to primary, raises match request.
// (RQ17) Both edge selectors accept the both-edges setting in capture modes.
// (RQ18) Supports free-running capture and restart-on-first-edge measurement.
// (RQ19) Software writes capture control, compare, clock select, then mode.
// (RQ20) Two-capture use needs both input pins configured as timer inputs.
// (RQ21) Edge codes: 00 falling, 01 rising, 11 both, 10 detects nothing.
// (RQ22) Clock codes: main, divide by four, divide by sixty-four, filtered pin.
// (RQ23) Software stops the timer before writing prescaler config.
// (RQ24) Capture latches the count of the cycle with the confirming sample.
module timer_event_counter (
    // Clock and reset.
    input wire logic clk,
    input wire logic srst,
    // Register port.
    input timer_pkg::reg_req_t req,
    output logic [15:0] rdata,
    // Timer pins.
    input wire logic first_timer_input,
    input wire logic second_timer_input,
    output logic timer_output_pin,
    output logic timer_output_enable,
    // Requests and flags.
    output logic match_irq,
    output logic capture_irq,
    output logic overflow_flag
);

    timer_pkg::state_t st;
    timer_pkg::state_t next_st;

    logic tick4;
    logic tick8;
    logic tick64;
    logic running;
    logic [1:0] mode;
    logic [1:0] clock_sel;
    logic [1:0] first_edge_sel;
    logic [1:0] second_edge_sel;
    logic ev_edge;
    logic cnt_tick;
    logic first_confirm;
    logic second_confirm;
    logic cap_first;
    logic cap_first_inv;
    logic cap_second;
    logic ovf_set;
    logic ovf_clr;

    // A prohibited edge code matches nothing rather than guessing an edge.
    function automatic logic edge_ok(input logic [1:0] sel, input logic new_lvl);
        case (sel)
            `EDGE_FALL: edge_ok = !new_lvl; // see (RQ21)
            `EDGE_RISE: edge_ok = new_lvl;
            `EDGE_BOTH: edge_ok = 1'b1; // see (RQ17)
            default: edge_ok = 1'b0;
        endcase
    endfunction : edge_ok

    assign mode = st.timer_mode_control[`MODE_LSB +: 2];
    assign clock_sel = st.prescaler_config[`PCFG_CLOCK_SEL_LSB +: 2]; // see (RQ2)
    assign first_edge_sel = st.prescaler_config[`PCFG_FIRST_EDGE_LSB +: 2]; // see (RQ9)
    assign second_edge_sel = st.prescaler_config[`PCFG_SECOND_EDGE_LSB +: 2]; // see (RQ16)
    assign running = (mode != `MODE_STOP);

    assign tick4 = ((st.div & `DIV4_MASK) == `DIV4_MASK);
    assign tick8 = ((st.div & `DIV8_MASK) == `DIV8_MASK);
    assign tick64 = (st.div == `DIV64_MASK);

    // Event input filter at the clock over eight, independent of the count clock.
    assign ev_edge = tick8 && (first_timer_input == st.ev_filt.smp)
        && (first_timer_input != st.ev_filt.lvl)
        && edge_ok(first_edge_sel, first_timer_input); // see (RQ10)

    always_comb begin
        case (clock_sel)
            `CLK_SEL_MAIN: cnt_tick = 1'b1; // see (RQ22)
            `CLK_SEL_DIV4: cnt_tick = tick4;
            `CLK_SEL_DIV64: cnt_tick = tick64;
            default: cnt_tick = ev_edge; // see (RQ6)
        endcase
    end

    // Capture filters sample at the count clock.
    assign first_confirm = cnt_tick && (first_timer_input == st.first_filt.smp)
        && (first_timer_input != st.first_filt.lvl); // see (RQ13)
    assign second_confirm = cnt_tick && (second_timer_input == st.second_filt.smp)
        && (second_timer_input != st.second_filt.lvl);
    assign cap_first = running && first_confirm && edge_ok(first_edge_sel, first_timer_input);
    // The inverse-edge capture is meaningless with both edges selected.
    assign cap_first_inv = running && first_confirm && (mode == `MODE_FREE_RUN)
        && st.capture_compare_control[`CCC_INV_EDGE_BIT] && (first_edge_sel != `EDGE_BOTH)
        && edge_ok(first_edge_sel, !first_timer_input);
    assign cap_second = running && second_confirm && (mode == `MODE_FREE_RUN)
        && st.capture_compare_control[`CCC_PRI_CAPTURE_BIT]
        && edge_ok(second_edge_sel, second_timer_input);

    assign ovf_clr = req.we && (req.addr == `OFS_STATUS) && req.wdata[`STATUS_OVF_BIT];

    always_comb begin
        next_st = st;
        ovf_set = 1'b0;
        next_st.div = st.div + 6'h01;
        next_st.match_irq = 1'b0;
        next_st.capture_irq = 1'b0;
        next_st.rdata = `RST_WORD;

        if (req.re) begin
            case (req.addr)
                `OFS_UP_COUNTER: next_st.rdata = st.up_counter; // see (RQ12)
                `OFS_PRIMARY: next_st.rdata = st.primary_compare_capture;
                `OFS_SECONDARY: next_st.rdata = st.secondary_compare_capture;
                `OFS_MODE_CONTROL: next_st.rdata = {13'h0000, st.timer_mode_control};
                `OFS_PRESCALER_CONFIG: next_st.rdata = {8'h00, st.prescaler_config};
                `OFS_CAPTURE_CONTROL: next_st.rdata = {14'h0000, st.capture_compare_control};
                `OFS_STATUS: next_st.rdata = {15'h0000, st.overflow_flag};
                default: next_st.rdata = `RST_WORD;
            endcase
        end

        if (req.we) begin
            case (req.addr)
                `OFS_PRIMARY: next_st.primary_compare_capture = req.wdata;
                `OFS_SECONDARY: next_st.secondary_compare_capture = req.wdata;
                `OFS_MODE_CONTROL: next_st.timer_mode_control = req.wdata[2:0];
                `OFS_PRESCALER_CONFIG: begin
                    next_st.prescaler_config = req.wdata[7:0] & `PCFG_WRITE_MASK;
                end
                `OFS_CAPTURE_CONTROL: next_st.capture_compare_control = req.wdata[1:0];
                default: begin
                end
            endcase
        end

        // Stopped filters follow the pin so a level held high is no edge on restart.
        if (!running) begin
            next_st.up_counter = `RST_WORD;
            next_st.ev_filt = '{smp: first_timer_input, lvl: first_timer_input};
            next_st.first_filt = '{smp: first_timer_input, lvl: first_timer_input};
            next_st.second_filt = '{smp: second_timer_input, lvl: second_timer_input};
        end else begin
            if (tick8) begin
                next_st.ev_filt.smp = first_timer_input;
                if (first_timer_input == st.ev_filt.smp) begin
                    next_st.ev_filt.lvl = first_timer_input;
                end
            end
            if (cnt_tick) begin
                next_st.first_filt.smp = first_timer_input;
                next_st.second_filt.smp = second_timer_input;
                if (first_confirm) begin
                    next_st.first_filt.lvl = first_timer_input;
                end
                if (second_confirm) begin
                    next_st.second_filt.lvl = second_timer_input;
                end
            end

            case (mode)
                `MODE_CLEAR_ON_MATCH: begin
                    if (cnt_tick) begin
                        // A compare below the count is passed, so the count wraps at FFFFH.
                        if (st.up_counter == st.primary_compare_capture) begin
                            next_st.up_counter = `RST_WORD; // see (RQ1) (RQ7) (RQ3)
                            next_st.match_irq = 1'b1;
                            next_st.tout = !st.tout;
                            ovf_set = (st.primary_compare_capture == `COUNT_MAX); // see (RQ5)
                        end else begin
                            next_st.up_counter = st.up_counter + 16'h0001; // see (RQ4)
                        end
                    end
                end
                `MODE_FREE_RUN: begin
                    if (cnt_tick) begin
                        next_st.up_counter = st.up_counter + 16'h0001;
                        ovf_set = (st.up_counter == `COUNT_MAX);
                    end
                    if (cap_first) begin
                        next_st.secondary_compare_capture = st.up_counter; // see (RQ15) (RQ24)
                        next_st.capture_irq = 1'b1;
                    end
                    if (cap_second || cap_first_inv) begin
                        next_st.primary_compare_capture = st.up_counter; // see (RQ16)
                        next_st.match_irq = 1'b1;
                    end
                end
                `MODE_RESTART: begin
                    if (cap_first) begin
                        next_st.secondary_compare_capture = st.up_counter; // see (RQ18)
                        next_st.capture_irq = 1'b1;
                        next_st.up_counter = `RST_WORD;
                    end else if (cnt_tick) begin
                        next_st.up_counter = st.up_counter + 16'h0001;
                        ovf_set = (st.up_counter == `COUNT_MAX);
                    end
                end
                default: begin
                end
            endcase
        end

        // Only software clears overflow, and a new overflow wins over that clear.
        next_st.overflow_flag = (st.overflow_flag && !ovf_clr) || ovf_set; // see (RQ14)

        if (srst) begin
            next_st = '0;
        end
    end

    always_ff @(posedge clk) begin
        st <= next_st;
    end

    assign rdata = st.rdata;
    assign match_irq = st.match_irq;
    assign capture_irq = st.capture_irq;
    assign overflow_flag = st.overflow_flag;
    // The shared pin is never driven while it counts events.
    assign timer_output_enable = st.timer_mode_control[`MODE_OUT_EN_BIT]
        && (clock_sel != `CLK_SEL_PIN_EDGE); // see (RQ11)
    assign timer_output_pin = timer_output_enable && st.tout;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    a_match_clears: assert property ( // see (RQ1)
        (mode == `MODE_CLEAR_ON_MATCH) && cnt_tick && !req.we
        && (st.up_counter == st.primary_compare_capture)
        |=> (st.up_counter == 16'h0000) && match_irq)
        else $error("match did not clear the counter");

    a_count_steps: assert property ( // see (RQ3)
        (mode == `MODE_CLEAR_ON_MATCH) && cnt_tick && !req.we
        && (st.up_counter != st.primary_compare_capture)
        |=> (st.up_counter == $past(st.up_counter) + 16'h0001) && !match_irq)
        else $error("counter did not step by one");

    a_ovf_only_max: assert property ( // see (RQ5)
        (mode == `MODE_CLEAR_ON_MATCH) && !overflow_flag ##1 overflow_flag
        |-> $past(st.primary_compare_capture) == 16'hFFFF)
        else $error("overflow without FFFF compare");

    a_ovf_sticky: assert property ( // see (RQ14)
        overflow_flag && !ovf_clr |=> overflow_flag)
        else $error("overflow cleared by hardware");

    a_capture_second: assert property ( // see (RQ15)
        (mode == `MODE_FREE_RUN) && cap_first && !req.we
        |=> (st.secondary_compare_capture == $past(st.up_counter)) && capture_irq)
        else $error("first input capture missed");

    a_capture_primary: assert property ( // see (RQ16)
        cap_second && !req.we
        |=> (st.primary_compare_capture == $past(st.up_counter)) && match_irq)
        else $error("second input capture missed");

    a_restart_clear: assert property ( // see (RQ18)
        (mode == `MODE_RESTART) && cap_first |=> st.up_counter == 16'h0000 && capture_irq)
        else $error("restart did not clear counter");

    a_div4_spacing: assert property ( // see (RQ22)
        tick4 |=> !tick4 [*3] ##1 tick4)
        else $error("divide by four spacing wrong");

    a_event_filter: assert property ( // see (RQ10)
        ev_edge |-> first_timer_input == $past(first_timer_input, 8))
        else $error("event edge without two equal samples");

    a_edge_code_bad: assert property ( // see (RQ21)
        (first_edge_sel == 2'h2) |-> !cap_first && !ev_edge)
        else $error("prohibited edge code detected an edge");

    a_pin_not_driven: assert property ( // see (RQ11)
        (clock_sel == `CLK_SEL_PIN_EDGE) |-> !timer_output_enable && !timer_output_pin)
        else $error("event pin driven as output");

    a_event_hold: assert property ( // see (RQ6)
        (mode == `MODE_CLEAR_ON_MATCH) && (clock_sel == `CLK_SEL_PIN_EDGE) && !ev_edge
        |=> $stable(st.up_counter))
        else $error("event counter moved without an edge");

    a_event_match: assert property ( // see (RQ7)
        (mode == `MODE_CLEAR_ON_MATCH) && (clock_sel == `CLK_SEL_PIN_EDGE) && ev_edge
        && (st.up_counter == st.primary_compare_capture)
        |=> (st.up_counter == 16'h0000) && match_irq)
        else $error("event match did not clear the counter");

    a_div8_spacing: assert property ( // see (RQ10)
        tick8 |=> !tick8 [*7] ##1 tick8)
        else $error("event sampling rate wrong");

    a_edge_rise_only: assert property ( // see (RQ21)
        (first_edge_sel == `EDGE_RISE) && (ev_edge || cap_first) |-> first_timer_input)
        else $error("rising edge code accepted a falling edge");

    a_edge_fall_only: assert property ( // see (RQ21)
        (first_edge_sel == `EDGE_FALL) && (ev_edge || cap_first) |-> !first_timer_input)
        else $error("falling edge code accepted a rising edge");

    a_second_code_bad: assert property ( // see (RQ21)
        (second_edge_sel == 2'h2) |-> !cap_second)
        else $error("prohibited second edge code captured");

    a_inverse_capture: assert property ( // see (RQ24)
        cap_first_inv && !req.we
        |=> (st.primary_compare_capture == $past(st.up_counter)) && match_irq)
        else $error("inverse edge capture missed");

    a_both_edges: assert property ( // see (RQ17)
        running && first_confirm && (first_edge_sel == `EDGE_BOTH) |-> cap_first)
        else $error("both-edge setting missed an edge");

    a_count_read: assert property ( // see (RQ12)
        req.re && (req.addr == `OFS_UP_COUNTER) |=> rdata == $past(st.up_counter))
        else $error("counter read returned a stale value");

    a_restart_steps: assert property ( // see (RQ18)
        (mode == `MODE_RESTART) && cnt_tick && !cap_first
        |=> st.up_counter == $past(st.up_counter) + 16'h0001)
        else $error("restart counter did not step");

    a_capture_on_tick: assert property ( // see (RQ13)
        cap_first || cap_second || cap_first_inv |-> cnt_tick)
        else $error("capture outside a count clock sample");

    a_output_quiet: assert property ( // see (RQ11)
        !timer_output_enable |-> !timer_output_pin)
        else $error("disabled output pin not low");

    a_ovf_clear: assert property ( // see (RQ14)
        overflow_flag && ovf_clr && !ovf_set |=> !overflow_flag)
        else $error("software clear of overflow ignored");

    a_ovf_held_low: assert property ( // see (RQ5)
        (mode == `MODE_CLEAR_ON_MATCH) && !overflow_flag
        && (st.primary_compare_capture != `COUNT_MAX) |=> !overflow_flag)
        else $error("overflow set with compare below FFFF");

endmodule : timer_event_counter

// *** timer_pkg.sv ***
package timer_pkg;

    typedef struct packed {
        logic we;
        logic re;
        logic [2:0] addr;
        logic [15:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic smp;
        logic lvl;
    } filt_t;

    typedef struct packed {
        logic [15:0] up_counter;
        logic [15:0] primary_compare_capture;
        logic [15:0] secondary_compare_capture;
        logic [2:0] timer_mode_control;
        logic [7:0] prescaler_config;
        logic [1:0] capture_compare_control;
        logic overflow_flag;
        logic [5:0] div;
        filt_t ev_filt;
        filt_t first_filt;
        filt_t second_filt;
        logic tout;
        logic match_irq;
        logic capture_irq;
        logic [15:0] rdata;
    } state_t;

endpackage : timer_pkg
